/* design/charge_current_limit_regs.sv */
module charge_current_limit_regs
    import charger_regs_pkg::*;
#(
    parameter logic [39:0] hour_cycles = HOUR_CYCLES
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic standby_supply_valid_i,
    input wire logic safe_output_power_good_i,
    input wire logic charge_enable_i,
    input wire logic fast_charge_active_i,
    input wire logic converter_on_i,
    input wire logic [3:0] charger_state_detail_i,
    output logic [10:0] charge_limit_ma_o,
    output logic [10:0] input_limit_ma_o,
    output logic input_limit_on_o,
    output logic restart_threshold_sel_o,
    output logic charge_suspend_o,
    output logic [3:0] charger_state_detail_o
);
    import charger_regs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    i2c_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_reg, tx_next;
    logic [7:0] ptr_reg, ptr_next;
    logic rw_reg, rw_next;
    logic nack_reg, nack_next;
    logic sda_oe_reg, sda_oe_next;
    logic scl_prev_reg, sda_prev_reg, pg_prev_reg;
    logic [4:0] charge_current_code_reg;
    logic [2:0] fast_charge_timer_code_reg;
    logic restart_threshold_sel_reg;
    logic [5:0] input_limit_code_reg;
    logic [1:0] write_protect_key_reg;
    logic [10:0] charge_limit_reg, input_limit_reg;
    logic input_on_reg, suspend_reg;
    logic [3:0] detail_reg;
    logic [10:0] charge_ma, input_ma;
    logic input_off, timer_fault;

    // ------------------------------------------------------------
    // bus line events
    // ------------------------------------------------------------
    wire logic scl_rise = scl_i && !scl_prev_reg;
    wire logic scl_fall = !scl_i && scl_prev_reg;
    wire logic start_seen = scl_i && scl_prev_reg && sda_prev_reg && !sda_i;
    wire logic stop_seen = scl_i && scl_prev_reg && !sda_prev_reg && sda_i;
    wire logic byte_full = cnt_reg == BYTE_BITS;
    wire logic addr_hit = shift_reg[7:1] == DEV_ADDR;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire logic unlocked = write_protect_key_reg == PROT_UNLOCK;
    wire logic wr_stb = (state_reg == I2C_WDATA) && scl_fall && byte_full && !start_seen &&
                        !stop_seen;
    wire logic wr_fast = wr_stb && (ptr_reg == FAST_CHARGE_SETTING_OFS) && unlocked;
    wire logic wr_input = wr_stb && (ptr_reg == INPUT_LIMIT_SETTING_OFS) && unlocked;
    wire logic wr_prot = wr_stb && (ptr_reg == PROTECT_OFS);
    // a power event outranks a host write in the same cycle
    wire logic defaults_evt = !standby_supply_valid_i ||
                              (safe_output_power_good_i && !pg_prev_reg);
    wire logic [7:0] fast_rd = {fast_charge_timer_code_reg, charge_current_code_reg};
    wire logic [7:0] input_rd = {1'b0, restart_threshold_sel_reg, input_limit_code_reg};
    wire logic [7:0] prot_rd = {4'h0, write_protect_key_reg, 2'h0};
    wire logic [7:0] rd_byte = (ptr_reg == FAST_CHARGE_SETTING_OFS) ? fast_rd :
                               (ptr_reg == INPUT_LIMIT_SETTING_OFS) ? input_rd :
                               (ptr_reg == PROTECT_OFS) ? prot_rd : 8'h00;

    // ------------------------------------------------------------
    // serial slave sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = scl_rise ? cnt_reg + 4'h1 : cnt_reg;
        shift_next = scl_rise ? {shift_reg[6:0], sda_i} : shift_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        nack_next = nack_reg;
        sda_oe_next = sda_oe_reg;
        if (start_seen) begin
            state_next = I2C_ADDR;
            cnt_next = 4'h0;
            sda_oe_next = 1'b0;
        end else if (stop_seen) begin
            state_next = I2C_IDLE;
            sda_oe_next = 1'b0;
        end else if (scl_fall) begin
            case (state_reg)
                I2C_ADDR: begin
                    if (byte_full && addr_hit) begin
                        rw_next = shift_reg[0];
                        sda_oe_next = 1'b1;
                        state_next = I2C_ADDR_ACK;
                    end else if (byte_full) begin
                        state_next = I2C_IDLE;
                    end
                end
                I2C_ADDR_ACK: begin
                    cnt_next = 4'h0;
                    if (rw_reg) begin
                        tx_next = rd_byte;
                        sda_oe_next = !rd_byte[7];
                        state_next = I2C_RDATA;
                    end else begin
                        sda_oe_next = 1'b0;
                        state_next = I2C_REG;
                    end
                end
                I2C_REG: begin
                    if (byte_full) begin
                        ptr_next = shift_reg;
                        sda_oe_next = 1'b1;
                        state_next = I2C_REG_ACK;
                    end
                end
                I2C_REG_ACK, I2C_WDATA_ACK: begin
                    cnt_next = 4'h0;
                    sda_oe_next = 1'b0;
                    state_next = I2C_WDATA;
                end
                I2C_WDATA: begin
                    if (byte_full) begin
                        ptr_next = ptr_reg + 8'h01;
                        sda_oe_next = 1'b1;
                        state_next = I2C_WDATA_ACK;
                    end
                end
                I2C_RDATA: begin
                    if (byte_full) begin
                        ptr_next = ptr_reg + 8'h01;
                        sda_oe_next = 1'b0;
                        state_next = I2C_RACK;
                    end else begin
                        tx_next = {tx_reg[6:0], 1'b0};
                        sda_oe_next = !tx_reg[6];
                    end
                end
                I2C_RACK: begin
                    cnt_next = 4'h0;
                    if (nack_reg) begin
                        state_next = I2C_IDLE;
                    end else begin
                        tx_next = rd_byte;
                        sda_oe_next = !rd_byte[7];
                        state_next = I2C_RDATA;
                    end
                end
                default: begin
                    state_next = I2C_IDLE;
                end
            endcase
        end else if (scl_rise && (state_reg == I2C_RACK)) begin
            nack_next = sda_i;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= I2C_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            // idle high, so no false rise right after reset
            pg_prev_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            nack_reg <= nack_next;
            sda_oe_reg <= sda_oe_next;
            scl_prev_reg <= scl_i;
            sda_prev_reg <= sda_i;
            pg_prev_reg <= safe_output_power_good_i;
        end
    end

    // ------------------------------------------------------------
    // setting registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            charge_current_code_reg <= CHG_CODE_RST;
            fast_charge_timer_code_reg <= TIMER_CODE_RST;
            restart_threshold_sel_reg <= RESTART_RST;
            input_limit_code_reg <= INPUT_CODE_RST;
            write_protect_key_reg <= PROT_KEY_RST;
        end else if (defaults_evt) begin
            charge_current_code_reg <= CHG_CODE_RST;
            fast_charge_timer_code_reg <= TIMER_CODE_RST;
            restart_threshold_sel_reg <= RESTART_RST;
            input_limit_code_reg <= INPUT_CODE_RST;
            write_protect_key_reg <= PROT_KEY_RST;
        end else begin
            if (wr_fast) begin
                fast_charge_timer_code_reg <= shift_reg[TIMER_CODE_LSB +: 3];
                charge_current_code_reg <= shift_reg[CHG_CODE_LSB +: 5];
            end
            if (wr_input) begin
                restart_threshold_sel_reg <= shift_reg[RESTART_BIT];
                input_limit_code_reg <= shift_reg[INPUT_CODE_LSB +: 6];
            end
            if (wr_prot) begin
                write_protect_key_reg <= shift_reg[PROT_KEY_LSB +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // decode and timer
    // ------------------------------------------------------------
    current_decode u_decode (
        .charge_current_code_i(charge_current_code_reg),
        .input_limit_code_i(input_limit_code_reg),
        .charge_ma_o(charge_ma),
        .input_ma_o(input_ma),
        .input_off_o(input_off)
    );

    // the fault holds until charging is disabled or defaults return
    fast_charge_timer #(
        .hour_cycles(hour_cycles)
    ) u_timer (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .clear_i(defaults_evt || !charge_enable_i),
        .timer_code_i(fast_charge_timer_code_reg),
        .fast_active_i(fast_charge_active_i),
        .fault_o(timer_fault)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    wire logic charging = charge_enable_i && !timer_fault;
    wire logic [10:0] charge_limit_next = charging ? charge_ma : 11'h000;
    wire logic [10:0] input_limit_next = converter_on_i ? input_ma : 11'h000;
    wire logic input_on_next = converter_on_i && !input_off;
    wire logic [3:0] detail_next = timer_fault ? STATE_TIMER_FAULT :
                                   charger_state_detail_i;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            charge_limit_reg <= 11'h000;
            input_limit_reg <= 11'h000;
            input_on_reg <= 1'b0;
            suspend_reg <= 1'b0;
            detail_reg <= 4'h0;
        end else begin
            charge_limit_reg <= charge_limit_next;
            input_limit_reg <= input_limit_next;
            input_on_reg <= input_on_next;
            suspend_reg <= timer_fault;
            detail_reg <= detail_next;
        end
    end

    // open-drain: data level is always low, the enable carries the bit
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_reg;
    assign charge_limit_ma_o = charge_limit_reg;
    assign input_limit_ma_o = input_limit_reg;
    assign input_limit_on_o = input_on_reg;
    assign restart_threshold_sel_o = restart_threshold_sel_reg;
    assign charge_suspend_o = suspend_reg;
    assign charger_state_detail_o = detail_reg;
endmodule : charge_current_limit_regs

/* design/charger_regs_pkg.sv */
package charger_regs_pkg;
    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h6a;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] FAST_CHARGE_SETTING_OFS = 8'h06;
    localparam logic [7:0] INPUT_LIMIT_SETTING_OFS = 8'h07;
    localparam logic [7:0] PROTECT_OFS = 8'h0a;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TIMER_CODE_LSB = 5;
    localparam int CHG_CODE_LSB = 0;
    localparam int RESTART_BIT = 6;
    localparam int INPUT_CODE_LSB = 0;
    localparam int PROT_KEY_LSB = 2;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [4:0] CHG_CODE_RST = 5'h0a;
    localparam logic [2:0] TIMER_CODE_RST = 3'h2;
    localparam logic RESTART_RST = 1'b0;
    localparam logic [5:0] INPUT_CODE_RST = 6'h14;
    localparam logic [1:0] PROT_KEY_RST = 2'h0;
    localparam logic [1:0] PROT_UNLOCK = 2'h3;

    // ------------------------------------------------------------
    // current decoding
    // ------------------------------------------------------------
    localparam logic [4:0] CHG_FLOOR_CODE = 5'h06;
    localparam logic [10:0] CHG_FLOOR_MA = 11'h0fa;
    localparam logic [10:0] CHG_STEP_MA = 11'h032;
    localparam logic [5:0] IN_FLOOR_CODE = 6'h0a;
    localparam logic [10:0] IN_FLOOR_MA = 11'h064;
    localparam logic [10:0] IN_STEP_MA = 11'h019;
    localparam logic [5:0] IN_MAX_CODE = 6'h3c;
    localparam logic [10:0] IN_MAX_MA = 11'h5dc;
    localparam logic [5:0] IN_DISABLE_CODE = 6'h3f;

    // ------------------------------------------------------------
    // fast-charge timer
    // ------------------------------------------------------------
    localparam logic [2:0] TIMER_OFF_CODE = 3'h0;
    localparam logic [3:0] TIMER_HOUR_OFFSET = 4'h3;
    localparam longint CLK_HZ = 64'h17d7840;
    localparam longint FC_TIMER_HOUR_S = 64'he10;
    localparam logic [39:0] HOUR_CYCLES = 40'(CLK_HZ * FC_TIMER_HOUR_S);
    localparam logic [3:0] STATE_TIMER_FAULT = 4'h6;

    typedef enum logic [3:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ADDR_ACK,
        I2C_REG,
        I2C_REG_ACK,
        I2C_WDATA,
        I2C_WDATA_ACK,
        I2C_RDATA,
        I2C_RACK
    } i2c_state_e;
endpackage : charger_regs_pkg

/* design/current_decode.sv */
module current_decode
    import charger_regs_pkg::*;
(
    input wire logic [4:0] charge_current_code_i,
    input wire logic [5:0] input_limit_code_i,
    output logic [10:0] charge_ma_o,
    output logic [10:0] input_ma_o,
    output logic input_off_o
);
    // ------------------------------------------------------------
    // code to milliamps
    // ------------------------------------------------------------
    wire logic chg_floor = charge_current_code_i < CHG_FLOOR_CODE;
    wire logic [10:0] chg_scaled = 11'(charge_current_code_i) * CHG_STEP_MA;
    wire logic in_floor = input_limit_code_i < IN_FLOOR_CODE;
    wire logic in_top = input_limit_code_i > IN_MAX_CODE;
    wire logic [10:0] in_scaled = 11'(input_limit_code_i) * IN_STEP_MA;

    assign charge_ma_o = chg_floor ? CHG_FLOOR_MA : chg_scaled;
    // unlisted codes above the top step hold the top value
    assign input_ma_o = in_floor ? IN_FLOOR_MA : (in_top ? IN_MAX_MA : in_scaled);
    assign input_off_o = input_limit_code_i == IN_DISABLE_CODE;
endmodule : current_decode

/* design/fast_charge_timer.sv */
module fast_charge_timer
    import charger_regs_pkg::*;
#(
    parameter logic [39:0] hour_cycles = HOUR_CYCLES
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic [2:0] timer_code_i,
    input wire logic fast_active_i,
    output logic fault_o
);
    logic active_prev_reg;
    logic [39:0] cyc_reg;
    logic [3:0] hours_reg;
    logic fault_reg;

    // ------------------------------------------------------------
    // hour counting
    // ------------------------------------------------------------
    wire logic entry = fast_active_i && !active_prev_reg;
    wire logic restart = entry || clear_i;
    wire logic cyc_wrap = cyc_reg == (hour_cycles - 40'h1);
    wire logic [3:0] limit = {1'b0, timer_code_i} + TIMER_HOUR_OFFSET;
    wire logic expire = fast_active_i && (timer_code_i != TIMER_OFF_CODE) &&
                        (hours_reg == limit);
    wire logic [39:0] cyc_next = restart ? 40'h0 :
                                 (fast_active_i ? (cyc_wrap ? 40'h0 : cyc_reg + 40'h1) :
                                  cyc_reg);
    // saturate so a long stay never wraps back under the limit
    wire logic hour_tick = fast_active_i && cyc_wrap && (hours_reg != 4'hf);
    wire logic [3:0] hours_next = restart ? 4'h0 :
                                  (hour_tick ? hours_reg + 4'h1 : hours_reg);
    // set wins over clear
    wire logic fault_next = expire ? 1'b1 : (clear_i ? 1'b0 : fault_reg);

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            active_prev_reg <= 1'b0;
            cyc_reg <= 40'h0;
            hours_reg <= 4'h0;
            fault_reg <= 1'b0;
        end else begin
            active_prev_reg <= fast_active_i;
            cyc_reg <= cyc_next;
            hours_reg <= hours_next;
            fault_reg <= fault_next;
        end
    end

    assign fault_o = fault_reg;
endmodule : fast_charge_timer

/* dv/charge_limit_assertions.sv */
module charge_limit_assertions
    import charger_regs_pkg::*;
#(
    parameter logic [39:0] hour_cycles = HOUR_CYCLES
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic standby_supply_valid_i,
    input wire logic safe_output_power_good_i,
    input wire logic charge_enable_i,
    input wire logic fast_charge_active_i,
    input wire logic converter_on_i,
    input wire logic [3:0] charger_state_detail_i,
    input wire logic [10:0] charge_limit_ma_o,
    input wire logic [10:0] input_limit_ma_o,
    input wire logic input_limit_on_o,
    input wire logic restart_threshold_sel_o,
    input wire logic charge_suspend_o,
    input wire logic [3:0] charger_state_detail_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    charge_off_a:
        assert property (!charge_enable_i |=> charge_limit_ma_o == 11'h000)
        else $error("charge limit not zero while disabled");
    charge_range_a:
        assert property (charge_limit_ma_o == 11'h000 || (charge_limit_ma_o >= 11'h0fa
            && charge_limit_ma_o <= 11'h60e && charge_limit_ma_o % 11'h032 == 11'h000))
        else $error("charge limit off the step grid");
    input_off_a:
        assert property (!converter_on_i |=> input_limit_ma_o == 11'h000 && !input_limit_on_o)
        else $error("input limit active with converter off");
    input_range_a:
        assert property (input_limit_on_o |-> input_limit_ma_o == 11'h064 || (input_limit_ma_o
            >= 11'h0fa && input_limit_ma_o <= 11'h5dc && input_limit_ma_o % 11'h019 == 11'h000))
        else $error("input limit off the step grid");
    suspend_state_a:
        assert property (charge_suspend_o |-> charger_state_detail_o == 4'h6
            && charge_limit_ma_o == 11'h000)
        else $error("suspend without fault state");
    detail_pass_a:
        assert property (!charge_suspend_o && $past(resetn_i)
            |-> charger_state_detail_o == $past(charger_state_detail_i))
        else $error("detail not passed through");
    suspend_clear_a:
        assert property ((!charge_enable_i && !fast_charge_active_i) [*2] |=> !charge_suspend_o)
        else $error("suspend kept while disabled");
    standby_default_a:
        assert property (!standby_supply_valid_i ##1 charge_enable_i
            |=> charge_limit_ma_o == 11'h1f4 && !restart_threshold_sel_o)
        else $error("defaults not restored on standby loss");
    good_rise_a:
        assert property ($rose(safe_output_power_good_i) |=> !restart_threshold_sel_o)
        else $error("defaults not restored on power-good rise");
    sda_move_a:
        assert property ($rose(sda_oe_o) |-> !scl_i)
        else $error("data driven while clock high");
    fault_c: cover property ($rose(charge_suspend_o));
    off_code_c: cover property (converter_on_i && !input_limit_on_o);
    drive_c: cover property ($rose(sda_oe_o));
endmodule : charge_limit_assertions

bind charge_current_limit_regs charge_limit_assertions #(.hour_cycles(hour_cycles))
    charge_limit_assertions_i (.*);

/* dv/i2c_host_model.sv */
module i2c_host_model
    import charger_regs_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // bus phases, scl low four mclk and high two mclk per bit
    // ----------------------------------------
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick
    // sda moves mid-low, sampled at the end of high
    task automatic bit_io(input logic b, output logic r);
        sda_low_o <= !b;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        r = sda_i;
        scl_o <= 1'b0;
        tick(2);
    endtask : bit_io
    // also serves as repeated start from scl low
    task automatic start();
        sda_low_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        sda_low_o <= 1'b1;
        tick(2);
        scl_o <= 1'b0;
        tick(2);
    endtask : start
    task automatic stop();
        sda_low_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        sda_low_o <= 1'b0;
        tick(2);
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : put
    task automatic send(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
                        output logic ok);
        logic k0, k1, k2;
        start();
        put({a, 1'b0}, k0);
        put(o, k1);
        put(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask : send
    // single byte read, closed by a nack
    task automatic fetch(input logic [6:0] a, input logic [7:0] o, output logic [7:0] d,
                         output logic ok);
        logic k0, k1, k2, r;
        start();
        put({a, 1'b0}, k0);
        put(o, k1);
        start();
        put({a, 1'b1}, k2);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
        stop();
        ok = k0 & k1 & k2;
    endtask : fetch
endmodule : i2c_host_model

/* dv/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import charger_regs_pkg::*;
    logic mclk_i, resetn_i, scl_i, sda_low, sda_o, sda_oe_o;
    logic standby_supply_valid_i, safe_output_power_good_i, charge_enable_i;
    logic fast_charge_active_i, converter_on_i, input_limit_on_o;
    logic restart_threshold_sel_o, charge_suspend_o;
    logic [3:0] charger_state_detail_i, charger_state_detail_o;
    logic [10:0] charge_limit_ma_o, input_limit_ma_o;
    wire sda_i = !(sda_low | sda_oe_o);
    int miscompares = 0;
    int check_count = 0;
    int n;
    logic ok;
    logic [7:0] d;
    logic [4:0] cc[5] = '{5'h00, 5'h05, 5'h06, 5'h0a, 5'h1f};
    logic [5:0] ic[6] = '{6'h00, 6'h09, 6'h0a, 6'h0b, 6'h3c, 6'h3f};
    // short hour keeps timer runs brief
    charge_current_limit_regs #(.hour_cycles(40'h00_0000_000a)) charge_current_limit_regs_i (.*);
    i2c_host_model i2c_host_model_i (.mclk_i(mclk_i), .sda_i(sda_i), .scl_o(scl_i),
                                     .sda_low_o(sda_low));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
    endtask : tick
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i2c_host_model_i.send(DEV_ADDR, a, v, ok);
        check({15'h0000, ok}, 16'h0001);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i2c_host_model_i.fetch(DEV_ADDR, a, d, ok);
        check({8'h00, d}, {8'h00, e});
    endtask : rd
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // ----------------------------------------
    // clock, watchdog
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = !mclk_i;
    end
    initial begin
        tick(40000);
        miscompares++;
        give_verdict();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        resetn_i = 1'b0;
        standby_supply_valid_i = 1'b1;
        safe_output_power_good_i = 1'b1;
        charge_enable_i = 1'b1;
        fast_charge_active_i = 1'b0;
        converter_on_i = 1'b1;
        charger_state_detail_i = 4'h2;
        tick(5);
        resetn_i <= 1'b1;
        tick(1);
        rd(FAST_CHARGE_SETTING_OFS, 8'h4a);
        rd(INPUT_LIMIT_SETTING_OFS, 8'h14);
        check({5'h00, charge_limit_ma_o}, 16'h01f4);
        check({5'h00, input_limit_ma_o}, 16'h01f4);
        wr(FAST_CHARGE_SETTING_OFS, 8'hff);
        rd(FAST_CHARGE_SETTING_OFS, 8'h4a);
        wr(8'h0b, 8'h55);
        rd(8'h0b, 8'h00);
        wr(PROTECT_OFS, 8'h0c);
        foreach (cc[i]) begin
            wr(FAST_CHARGE_SETTING_OFS, {3'h7, cc[i]});
            rd(FAST_CHARGE_SETTING_OFS, {3'h7, cc[i]});
            check({5'h00, charge_limit_ma_o}, (cc[i] < 5'h06) ? 16'h00fa :
                  16'h00fa + 16'(cc[i] - 5'h05) * 16'h0032);
        end
        foreach (ic[i]) begin
            wr(INPUT_LIMIT_SETTING_OFS, {2'h3, ic[i]});
            rd(INPUT_LIMIT_SETTING_OFS, {2'h1, ic[i]});
            check({15'h0000, input_limit_on_o}, {15'h0000, ic[i] != 6'h3f});
            if (ic[i] != 6'h3f) begin
                check({5'h00, input_limit_ma_o}, (ic[i] < 6'h0a) ? 16'h0064 :
                      16'h00fa + 16'(ic[i] - 6'h0a) * 16'h0019);
            end
        end
        check({15'h0000, restart_threshold_sel_o}, 16'h0001);
        converter_on_i <= 1'b0;
        charger_state_detail_i <= 4'h3;
        charge_enable_i <= 1'b0;
        tick(3);
        check({4'h0, input_limit_on_o, input_limit_ma_o}, 16'h0000);
        check({5'h00, charge_limit_ma_o}, 16'h0000);
        converter_on_i <= 1'b1;
        charge_enable_i <= 1'b1;
        wr(FAST_CHARGE_SETTING_OFS, 8'h2a);
        fast_charge_active_i <= 1'b1;
        tick(20);
        fast_charge_active_i <= 1'b0;
        tick(30);
        check({15'h0000, charge_suspend_o}, 16'h0000);
        fast_charge_active_i <= 1'b1;
        n = 0;
        while (charge_suspend_o !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check({15'h0000, n >= 40 && n <= 44}, 16'h0001);
        tick(1);
        check({charger_state_detail_o, 1'b0, charge_limit_ma_o}, 16'h6000);
        fast_charge_active_i <= 1'b0;
        charge_enable_i <= 1'b0;
        tick(3);
        check({15'h0000, charge_suspend_o}, 16'h0000);
        check({12'h000, charger_state_detail_o}, 16'h0003);
        charge_enable_i <= 1'b1;
        wr(FAST_CHARGE_SETTING_OFS, 8'h0a);
        fast_charge_active_i <= 1'b1;
        tick(80);
        check({15'h0000, charge_suspend_o}, 16'h0000);
        fast_charge_active_i <= 1'b0;
        standby_supply_valid_i <= 1'b0;
        tick(1);
        standby_supply_valid_i <= 1'b1;
        tick(1);
        rd(FAST_CHARGE_SETTING_OFS, 8'h4a);
        rd(INPUT_LIMIT_SETTING_OFS, 8'h14);
        wr(PROTECT_OFS, 8'h0c);
        wr(INPUT_LIMIT_SETTING_OFS, 8'h7f);
        rd(INPUT_LIMIT_SETTING_OFS, 8'h7f);
        safe_output_power_good_i <= 1'b0;
        tick(2);
        safe_output_power_good_i <= 1'b1;
        tick(2);
        rd(INPUT_LIMIT_SETTING_OFS, 8'h14);
        i2c_host_model_i.fetch(7'h6b, FAST_CHARGE_SETTING_OFS, d, ok);
        check({14'h0000, sda_o, ok}, 16'h0000);
        give_verdict();
    end
endmodule : tb
